// file: design/tcc_capture_channel.sv
/*
 * One input capture channel: pin synchroniser, edge select, and the
 * hold path that delays a capture blocked by a capture register read.
 * Assumes the count input is on sys_clk_in and the pin is asynchronous.
 */
`timescale 1ns/100ps
module tcc_capture_channel (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic pin_in,
    input wire logic [1:0] edge_sel_in,
    input wire logic enable_in,
    input wire logic block_in,
    input wire logic [15:0] count_in,
    output tcc_pkg::tcc_cap_t cap_out
);

    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic pend_q;
    logic pend_d;
    logic [15:0] pend_val_q;
    logic [15:0] pend_val_d;
    tcc_pkg::tcc_cap_t cap_q;
    tcc_pkg::tcc_cap_t cap_d;
    logic rise;
    logic fall;
    logic hit;

    // two-stage pin synchroniser, then edge history
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // edge select: low bit rising, high bit falling, both any edge
    assign rise = sync2_q & ~prev_q;
    assign fall = ~sync2_q & prev_q;
    assign hit = enable_in & ((edge_sel_in[0] & rise) | (edge_sel_in[1] & fall));

    // transfer now, or hold one cycle while a capture register read blocks
    always_comb begin
        cap_d = '0;
        pend_d = pend_q;
        pend_val_d = pend_val_q;
        if (block_in) begin
            if (hit) begin
                pend_d = 1'b1;
                pend_val_d = count_in;
            end
        end else if (pend_q) begin
            cap_d.load = 1'b1;
            cap_d.value = pend_val_q;
            pend_d = hit;
            pend_val_d = count_in;
        end else if (hit) begin
            cap_d.load = 1'b1;
            cap_d.value = count_in;
        end
    end

    // capture strobe and held value registers
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            pend_q <= 1'b0;
            pend_val_q <= 16'h0000;
            cap_q <= '0;
        end else begin
            pend_q <= pend_d;
            pend_val_q <= pend_val_d;
            cap_q <= cap_d;
        end
    end

    assign cap_out = cap_q;

    // assertions
    a_block_no_load: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        hit && block_in |=> !cap_out.load)
        else $error("capture transferred during a blocked cycle");
    a_block_held: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (hit && block_in) ##1 !block_in |=> cap_out.load && cap_out.value == $past(count_in, 2))
        else $error("blocked capture was lost or changed");

endmodule // tcc_capture_channel

// file: design/tcc_pkg.sv
/*
 * Shared constants and types of the timer capture/compare unit:
 * register indices and byte addresses, reset values, field positions,
 * channel counts and the capture event carrier.
 * Assumes an 8-bit APB address and one 32-bit word per register.
 */
package tcc_pkg;

    // register indices; the APB byte address is four times the index
    localparam logic [7:0] IDX_PORT_DATA = 8'h00;
    localparam logic [7:0] IDX_PORT_DIR = 8'h01;
    localparam logic [7:0] IDX_M1_MASK = 8'h0C;
    localparam logic [7:0] IDX_M1_DATA = 8'h0D;
    localparam logic [7:0] IDX_CAP1 = 8'h10;
    localparam logic [7:0] IDX_CAP2 = 8'h12;
    localparam logic [7:0] IDX_CAP3 = 8'h14;
    localparam logic [7:0] IDX_CMP1 = 8'h16;
    localparam logic [7:0] IDX_CMP2 = 8'h18;
    localparam logic [7:0] IDX_CMP3 = 8'h1A;
    localparam logic [7:0] IDX_CMP4 = 8'h1C;
    localparam logic [7:0] IDX_SHARED = 8'h1E;
    localparam logic [7:0] IDX_ACT = 8'h20;
    localparam logic [7:0] IDX_EDGE = 8'h21;
    localparam logic [7:0] IDX_MASK = 8'h22;
    localparam logic [7:0] IDX_FLAG = 8'h23;
    localparam logic [7:0] IDX_ACC = 8'h26;

    // byte addresses
    localparam logic [7:0] ADDR_PORT_DATA = {IDX_PORT_DATA[5:0], 2'b00};
    localparam logic [7:0] ADDR_PORT_DIR = {IDX_PORT_DIR[5:0], 2'b00};
    localparam logic [7:0] ADDR_M1_MASK = {IDX_M1_MASK[5:0], 2'b00};
    localparam logic [7:0] ADDR_M1_DATA = {IDX_M1_DATA[5:0], 2'b00};
    localparam logic [7:0] ADDR_CAP1 = {IDX_CAP1[5:0], 2'b00};
    localparam logic [7:0] ADDR_CAP2 = {IDX_CAP2[5:0], 2'b00};
    localparam logic [7:0] ADDR_CAP3 = {IDX_CAP3[5:0], 2'b00};
    localparam logic [7:0] ADDR_CMP1 = {IDX_CMP1[5:0], 2'b00};
    localparam logic [7:0] ADDR_CMP2 = {IDX_CMP2[5:0], 2'b00};
    localparam logic [7:0] ADDR_CMP3 = {IDX_CMP3[5:0], 2'b00};
    localparam logic [7:0] ADDR_CMP4 = {IDX_CMP4[5:0], 2'b00};
    localparam logic [7:0] ADDR_SHARED = {IDX_SHARED[5:0], 2'b00};
    localparam logic [7:0] ADDR_ACT = {IDX_ACT[5:0], 2'b00};
    localparam logic [7:0] ADDR_EDGE = {IDX_EDGE[5:0], 2'b00};
    localparam logic [7:0] ADDR_MASK = {IDX_MASK[5:0], 2'b00};
    localparam logic [7:0] ADDR_FLAG = {IDX_FLAG[5:0], 2'b00};
    localparam logic [7:0] ADDR_ACC = {IDX_ACC[5:0], 2'b00};

    // values after reset
    localparam logic [15:0] CMP_RST = 16'hFFFF;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [4:0] PIN_RST = 5'h00;

    // field positions and channel layout
    localparam int unsigned SEL_BIT = 2;
    localparam int unsigned N_CAP = 4;
    localparam int unsigned N_CMP = 5;
    localparam int unsigned N_PIN = 5;
    localparam int unsigned PIN_LO = 3;
    localparam int unsigned CAP_PIN [4] = '{2, 1, 0, 3};
    localparam int unsigned CAP_EDGE_POS [4] = '{4, 2, 0, 6};

    // one capture transfer: strobe plus the count to store
    typedef struct packed {
        logic load;
        logic [15:0] value;
    } tcc_cap_t;

endpackage

// file: design/tcc_top.sv
/*
 * Timer capture/compare unit: four capture channels, five compare
 * channels with pin actions, flag and mask registers, APB slave.
 * Assumes the free-running count is produced on sys_clk_in elsewhere and
 * that pin inputs are asynchronous; the bench resolves pin wires.
 */
`timescale 1ns/100ps
// Contract
// - two-bit edge field selects capture edge
// - selected edge copies whole count at once
// - pin edges synchronised before latching count
// - capture read blocks transfer one cycle
// - blocked capture is held, not lost
// - dedicated capture registers ignore reset
// - channels independent, same count same cycle
// - reset clears all edge fields
// - fourth capture only when select set
// - shared register ignores writes while capturing
// - software pin writes trigger fourth capture
// - reset clears direction and select bits
// - compare registers reset to all ones
// - five comparators check every count; the code runs the fifth (shared) comparator only while the select bit is clear
// - match sets flag; mask gates interrupt
// - pin action on every match regardless
// - two-bit field per channel picks action
// - first compare drives pins via mask/data
// - pin change lags match by sync delay
// - 00 off, 01 toggle, 10 low, 11 high
// - first match drives masked pins to data
// - compare write suppresses compare one cycle
module tcc_top (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [15:0] free_running_count_in,
    input wire logic [3:0] timer_pin_in,
    output logic [4:0] compare_pins_out,
    output logic [4:0] compare_pins_oe_out,
    output logic timer_irq_out
);

    // register state
    logic [15:0] cap_q [3];
    logic [15:0] cmp_q [4];
    logic [15:0] shared_q;
    logic [7:0] edge_q;
    logic [7:0] act_q;
    logic [7:0] mask_q;
    logic [7:0] flag_q;
    logic [7:0] flag_d;
    logic [4:0] m1mask_q;
    logic [4:0] m1data_q;
    logic [4:0] dir_q;
    logic [4:0] pin_q;
    logic [4:0] pin_d;
    logic sel_q;
    logic [4:0] inhib_q;
    logic [4:0] match_q;
    logic [15:0] count_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic irq_q;

    // decode wires
    logic commit;
    logic wr_commit;
    logic rd_commit;
    logic s_pdata, s_pdir, s_m1m, s_m1d, s_act, s_edge, s_mask, s_flag, s_acc;
    logic s_shared;
    logic [2:0] s_cap;
    logic [3:0] s_cmp;
    logic mapped;
    logic [31:0] rdata;
    logic [15:0] cmp_val [5];
    logic [4:0] cmp_en;
    logic [4:0] match;
    logic new_count;
    logic [3:0] cap_blk;
    logic [3:0] cap_en;
    logic [4:0] cap_set;
    logic [7:0] flag_set;
    tcc_pkg::tcc_cap_t cap_ev [4];

    // apb phases: one wait cycle, then the commit edge
    assign commit = psel_in & penable_in & pready_q;
    assign wr_commit = commit & pwrite_in;
    assign rd_commit = commit & ~pwrite_in;

    // address decode
    assign s_pdata = paddr_in == tcc_pkg::ADDR_PORT_DATA;
    assign s_pdir = paddr_in == tcc_pkg::ADDR_PORT_DIR;
    assign s_m1m = paddr_in == tcc_pkg::ADDR_M1_MASK;
    assign s_m1d = paddr_in == tcc_pkg::ADDR_M1_DATA;
    assign s_cap[0] = paddr_in == tcc_pkg::ADDR_CAP1;
    assign s_cap[1] = paddr_in == tcc_pkg::ADDR_CAP2;
    assign s_cap[2] = paddr_in == tcc_pkg::ADDR_CAP3;
    assign s_cmp[0] = paddr_in == tcc_pkg::ADDR_CMP1;
    assign s_cmp[1] = paddr_in == tcc_pkg::ADDR_CMP2;
    assign s_cmp[2] = paddr_in == tcc_pkg::ADDR_CMP3;
    assign s_cmp[3] = paddr_in == tcc_pkg::ADDR_CMP4;
    assign s_shared = paddr_in == tcc_pkg::ADDR_SHARED;
    assign s_act = paddr_in == tcc_pkg::ADDR_ACT;
    assign s_edge = paddr_in == tcc_pkg::ADDR_EDGE;
    assign s_mask = paddr_in == tcc_pkg::ADDR_MASK;
    assign s_flag = paddr_in == tcc_pkg::ADDR_FLAG;
    assign s_acc = paddr_in == tcc_pkg::ADDR_ACC;
    assign mapped = s_pdata | s_pdir | s_m1m | s_m1d | (|s_cap) | (|s_cmp) | s_shared
        | s_act | s_edge | s_mask | s_flag | s_acc;

    // read data mux; unimplemented bits read zero
    assign rdata = ({32{s_pdata}} & {24'h000000, pin_q, 3'b000})
        | ({32{s_pdir}} & {24'h000000, dir_q, 3'b000})
        | ({32{s_m1m}} & {24'h000000, m1mask_q, 3'b000})
        | ({32{s_m1d}} & {24'h000000, m1data_q, 3'b000})
        | ({32{s_cap[0]}} & {16'h0000, cap_q[0]})
        | ({32{s_cap[1]}} & {16'h0000, cap_q[1]})
        | ({32{s_cap[2]}} & {16'h0000, cap_q[2]})
        | ({32{s_cmp[0]}} & {16'h0000, cmp_q[0]})
        | ({32{s_cmp[1]}} & {16'h0000, cmp_q[1]})
        | ({32{s_cmp[2]}} & {16'h0000, cmp_q[2]})
        | ({32{s_cmp[3]}} & {16'h0000, cmp_q[3]})
        | ({32{s_shared}} & {16'h0000, shared_q})
        | ({32{s_act}} & {24'h000000, act_q})
        | ({32{s_edge}} & {24'h000000, edge_q})
        | ({32{s_mask}} & {24'h000000, mask_q})
        | ({32{s_flag}} & {24'h000000, flag_q})
        | ({32{s_acc}} & {29'h00000000, sel_q, 2'b00});

    // apb answer registers
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= psel_in & penable_in & ~pready_q;
            pslverr_q <= psel_in & penable_in & ~pready_q & ~mapped;
            prdata_q <= (psel_in & penable_in & ~pready_q & ~pwrite_in) ? rdata : 32'h00000000;
        end
    end

    // capture channels; a read of a capture register blocks its pair
    assign cap_en = {sel_q, 3'b111};
    assign cap_blk = {rd_commit & s_shared, rd_commit & s_cap[2], rd_commit & s_cap[1],
        rd_commit & s_cap[0]};
    genvar i;
    for (i = 0; i < tcc_pkg::N_CAP; i++) begin : g_cap
        tcc_capture_channel u_chan (
            .sys_clk_in(sys_clk_in),
            .srst_in(srst_in),
            .pin_in(timer_pin_in[tcc_pkg::CAP_PIN[i]]),
            .edge_sel_in(edge_q[tcc_pkg::CAP_EDGE_POS[i] +: 2]),
            .enable_in(cap_en[i]),
            .block_in(cap_blk[i]),
            .count_in(free_running_count_in),
            .cap_out(cap_ev[i])
        );
        assign cap_set[i] = cap_ev[i].load & cap_en[i];
    end
    assign cap_set[4] = 1'b0;

    // dedicated capture registers, untouched by reset
    always_ff @(posedge sys_clk_in) begin
        for (int n = 0; n < 3; n++) begin
            if (cap_ev[n].load) begin
                cap_q[n] <= cap_ev[n].value;
            end
        end
    end

    // comparators run once per new count; writes inhibit for one cycle
    assign new_count = free_running_count_in != count_q;
    assign cmp_en = {~sel_q, 4'b1111};
    assign cmp_val[0] = cmp_q[0];
    assign cmp_val[1] = cmp_q[1];
    assign cmp_val[2] = cmp_q[2];
    assign cmp_val[3] = cmp_q[3];
    assign cmp_val[4] = shared_q;
    genvar j;
    for (j = 0; j < tcc_pkg::N_CMP; j++) begin : g_cmp
        assign match[j] = new_count & cmp_en[j] & ~inhib_q[j]
            & (free_running_count_in == cmp_val[j]);
    end

    // flag order: compare one..four, shared, capture one..three
    assign flag_set = {match[0], match[1], match[2], match[3], match[4] | cap_set[3],
        cap_set[0], cap_set[1], cap_set[2]};
    assign flag_d = (flag_q & ~({8{wr_commit & s_flag}} & pwdata_in[7:0])) | flag_set;

    // compare, shared and write-inhibit registers
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            for (int n = 0; n < 4; n++) begin
                cmp_q[n] <= tcc_pkg::CMP_RST;
            end
            shared_q <= tcc_pkg::CMP_RST;
            inhib_q <= 5'h00;
        end else begin
            for (int n = 0; n < 4; n++) begin
                if (wr_commit & s_cmp[n]) begin
                    cmp_q[n] <= pwdata_in[15:0];
                end
            end
            if (cap_ev[3].load & sel_q) begin
                shared_q <= cap_ev[3].value;
            end else if (wr_commit & s_shared & ~sel_q) begin
                shared_q <= pwdata_in[15:0];
            end
            inhib_q <= {wr_commit & s_shared & ~sel_q, wr_commit & s_cmp[3],
                wr_commit & s_cmp[2], wr_commit & s_cmp[1], wr_commit & s_cmp[0]};
        end
    end

    // control, flag and mask registers
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            edge_q <= tcc_pkg::CTL_RST;
            act_q <= tcc_pkg::CTL_RST;
            mask_q <= tcc_pkg::CTL_RST;
            flag_q <= tcc_pkg::CTL_RST;
            m1mask_q <= tcc_pkg::PIN_RST;
            m1data_q <= tcc_pkg::PIN_RST;
            dir_q <= tcc_pkg::PIN_RST;
            sel_q <= 1'b0;
            count_q <= 16'h0000;
            match_q <= 5'h00;
            irq_q <= 1'b0;
        end else begin
            if (wr_commit & s_edge) edge_q <= pwdata_in[7:0];
            if (wr_commit & s_act) act_q <= pwdata_in[7:0];
            if (wr_commit & s_mask) mask_q <= pwdata_in[7:0];
            if (wr_commit & s_m1m) m1mask_q <= pwdata_in[7:3];
            if (wr_commit & s_m1d) m1data_q <= pwdata_in[7:3];
            if (wr_commit & s_pdir) dir_q <= pwdata_in[7:3];
            if (wr_commit & s_acc) sel_q <= pwdata_in[tcc_pkg::SEL_BIT];
            flag_q <= flag_d;
            count_q <= free_running_count_in;
            match_q <= match;
            irq_q <= |(flag_q & mask_q);
        end
    end

    // per-pin action: first compare has priority, then own channel, then software
    genvar g;
    for (g = 0; g < tcc_pkg::N_PIN; g++) begin : g_pin
        logic [1:0] act;
        logic own_hit;
        logic own_val;
        logic timer_own;
        if (g < 4) begin : g_own
            assign act = act_q[2 * g +: 2] & {2{cmp_en[4 - g]}};
            assign own_hit = match_q[4 - g] & (|act);
        end else begin : g_none
            assign act = 2'b00;
            assign own_hit = 1'b0;
        end
        assign own_val = act[1] ? act[0] : ~pin_q[g];
        assign timer_own = m1mask_q[g] | (|act);
        // software writes reach only pins the timer does not hold; this is
        // what lets software edges on the shared pin feed the fourth capture
        assign pin_d[g] = (match_q[0] & m1mask_q[g]) ? m1data_q[g]
            : own_hit ? own_val
            : (wr_commit & s_pdata & ~timer_own) ? pwdata_in[g + tcc_pkg::PIN_LO]
            : pin_q[g];
    end

    // pin latch
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            pin_q <= tcc_pkg::PIN_RST;
        end else begin
            pin_q <= pin_d;
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign compare_pins_out = pin_q;
    assign compare_pins_oe_out = dir_q;
    assign timer_irq_out = irq_q;

    // assertions
    a_edge_reset: assert property (@(posedge sys_clk_in)
        srst_in |=> edge_q == 8'h00 && !cap_ev[0].load)
        else $error("edge fields not cleared by reset");
    a_cmp_reset: assert property (@(posedge sys_clk_in)
        srst_in |=> shared_q == 16'hFFFF && cmp_q[0] == 16'hFFFF && cmp_q[3] == 16'hFFFF)
        else $error("compare registers not all ones after reset");
    a_sel_dir_reset: assert property (@(posedge sys_clk_in)
        srst_in |=> !sel_q && !compare_pins_oe_out[0])
        else $error("shared pin not input compare after reset");
    a_shared_wr_ign: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        wr_commit && s_shared && sel_q && !cap_ev[3].load |=> $stable(shared_q))
        else $error("shared register written while capturing");
    a_cap_store: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        cap_ev[1].load |=> cap_q[1] == $past(cap_ev[1].value))
        else $error("capture value not stored");
    a_match_flag: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        match[1] |=> flag_q[6] ##1 timer_irq_out == mask_q[6])
        else $error("compare match flag or interrupt wrong");
    a_cmp_inhibit: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        wr_commit && s_cmp[1] |=> !match[1])
        else $error("compare not suppressed after write");
    a_pin_action: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        match[1] && act_q[7:6] == 2'b11 && !m1mask_q[3] ##1 !match_q[0] |=> compare_pins_out[3])
        else $error("set action did not drive pin high");
    a_pin_toggle: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        match_q[1] && act_q[7:6] == 2'b01 && !match_q[0] |=> compare_pins_out[3] != $past(pin_q[3]))
        else $error("toggle action missing");
    a_multi_drive: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        match_q[0] && m1mask_q[4] |=> compare_pins_out[4] == $past(m1data_q[4]))
        else $error("first compare did not drive masked pin");
    a_cap_same: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        cap_ev[0].load && cap_ev[2].load && $past(cap_ev[0].load) == 1'b0
        && $past(cap_ev[2].load) == 1'b0 && !$past(cap_blk[0], 2) && !$past(cap_blk[2], 2)
        |-> cap_ev[0].value == cap_ev[2].value)
        else $error("simultaneous captures differ");

    c_capture: cover property (@(posedge sys_clk_in) disable iff (srst_in) cap_ev[0].load);
    c_shared_cap: cover property (@(posedge sys_clk_in) disable iff (srst_in)
        cap_ev[3].load && sel_q);
    c_compare: cover property (@(posedge sys_clk_in) disable iff (srst_in) match[4]);
    c_multi: cover property (@(posedge sys_clk_in) disable iff (srst_in)
        match_q[0] && m1mask_q != 5'h00);

endmodule // tcc_top

// file: sim/tcc_pin_model.sv
/*
 * Far-side model of the timer port pins: outside levels on the capture pins,
 * and the shared pin wire resolved from the unit's own drive.
 * Assumes the bench sets the outside levels just after a clock edge.
 */
`timescale 1ns/100ps
module tcc_pin_model (
    input wire logic [3:0] ext_level_in,
    input wire logic [4:0] drive_value_in,
    input wire logic [4:0] drive_enable_in,
    output logic [3:0] pin_level_out
);
    // capture pins follow the outside world; shared pin follows its driver when enabled, else the outside level
    assign pin_level_out[2:0] = ext_level_in[2:0];
    assign pin_level_out[3] = drive_enable_in[0] ? drive_value_in[0] : ext_level_in[3];
endmodule // tcc_pin_model

// file: sim/timer_capture_compare_unit_test.sv
/*
 * Self-checking bench of the timer capture/compare unit: reset values,
 * capture edges, compare actions, multi-pin compare and shared channel.
 * Assumes the pin model and an APB slave with one wait state.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module timer_capture_compare_unit_test;
    typedef struct packed {logic [7:0] a; logic [15:0] d; logic e;} tcc_row_t;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0;
    logic pen = 1'h0;
    logic pwr = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] cnt = 16'h0001;
    logic [3:0] ext = 4'h0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, irq, rerr;
    logic [3:0] pins;
    logic [4:0] cpo, cpoe;
    logic [15:0] exp1;
    int n_errors = 0;
    int tests_run = 0;
    tcc_row_t rows [9];
    logic [1:0] modes [4] = '{2'h3, 2'h0, 2'h1, 2'h2};
    logic [1:0] acts [5] = '{2'h0, 2'h3, 2'h2, 2'h1, 2'h1};
    logic [4:0] pseq = 5'h0A;

    tcc_top tcc_top_inst (.sys_clk_in(clk), .srst_in(rst), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .free_running_count_in(cnt),
        .timer_pin_in(pins), .compare_pins_out(cpo), .compare_pins_oe_out(cpoe),
        .timer_irq_out(irq));
    tcc_pin_model tcc_pin_model_inst (.ext_level_in(ext), .drive_value_in(cpo),
        .drive_enable_in(cpoe), .pin_level_out(pins));

    // clock and watchdog
    initial forever #20 clk = ~clk;
    initial begin
        #400000;
        n_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_sim();
    end

    // one APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'h1, a, {16'h0, d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        apb(1'h0, a, 32'h0);
        `CHK(rdat, {16'h0, e})
        `CHK(rerr, 1'h0)
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic step(input logic [15:0] v);
        @(posedge clk);
        cnt <= v;
    endtask
    // count steps onto a value just after a change
    task automatic hit(input logic [15:0] v);
        step(v - 16'h1);
        step(v);
        tick(4);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        rows = '{'{tcc_pkg::ADDR_CMP1, 16'hFFFF, 1'h0}, '{tcc_pkg::ADDR_CMP2, 16'hFFFF, 1'h0},
            '{tcc_pkg::ADDR_CMP3, 16'hFFFF, 1'h0}, '{tcc_pkg::ADDR_CMP4, 16'hFFFF, 1'h0},
            '{tcc_pkg::ADDR_SHARED, 16'hFFFF, 1'h0}, '{tcc_pkg::ADDR_EDGE, 16'h0, 1'h0},
            '{tcc_pkg::ADDR_PORT_DIR, 16'h0, 1'h0}, '{tcc_pkg::ADDR_ACC, 16'h0, 1'h0},
            '{8'hFC, 16'h0, 1'h1}};
        tick(4);
        rst <= 1'h0;
        foreach (rows[i]) begin
            apb(1'h0, rows[i].a, 32'h0);
            `CHK(rdat, {16'h0, rows[i].d})
            `CHK(rerr, rows[i].e)
        end
        // every edge code, rising then falling, on channel one
        foreach (modes[m]) begin
            wr(tcc_pkg::ADDR_EDGE, {8'h0, 2'h0, modes[m], 4'h0});
            for (int lv = 1; lv >= 0; lv--) begin
                step({2'h1, modes[m], 11'h0, lv[0]});
                ext[2] <= lv[0];
                tick(6);
                if (modes[m][lv == 0]) exp1 = cnt;
                rd(tcc_pkg::ADDR_CAP1, exp1);
            end
        end
        // three channels seeing edges on one count
        wr(tcc_pkg::ADDR_EDGE, 16'h0015);
        step(16'h2222);
        ext[2:0] <= 3'h7;
        tick(6);
        rd(tcc_pkg::ADDR_CAP1, 16'h2222);
        rd(tcc_pkg::ADDR_CAP2, 16'h2222);
        rd(tcc_pkg::ADDR_CAP3, 16'h2222);
        // an edge landing on the commit of a capture read is held one cycle
        ext[2] <= 1'h0;
        tick(4);
        step(16'h2A2A);
        fork
            rd(tcc_pkg::ADDR_CAP1, 16'h2222);
            begin
                @(posedge clk);
                ext[2] <= 1'h1;
            end
        join
        rd(tcc_pkg::ADDR_CAP1, 16'h2A2A);
        @(posedge clk);
        rst <= 1'h1;
        tick(2);
        rst <= 1'h0;
        rd(tcc_pkg::ADDR_CAP2, 16'h2222);
        rd(tcc_pkg::ADDR_EDGE, 16'h0000);
        // every pin action on channel two, flag never cleared
        wr(tcc_pkg::ADDR_PORT_DIR, 16'h00F8);
        wr(tcc_pkg::ADDR_MASK, 16'h0040);
        foreach (acts[k]) begin
            wr(tcc_pkg::ADDR_ACT, {8'h0, acts[k], 6'h0});
            wr(tcc_pkg::ADDR_CMP2, {12'h300, k[3:0]});
            hit({12'h300, k[3:0]});
            `CHK(cpo[3], pseq[k])
        end
        `CHK(cpoe, 5'h1F)
        `CHK(irq, 1'h1)
        wr(tcc_pkg::ADDR_MASK, 16'h0000);
        tick(2);
        `CHK(irq, 1'h0)
        rd(tcc_pkg::ADDR_FLAG, 16'h0040);
        wr(tcc_pkg::ADDR_FLAG, 16'h00FF);
        // count reaches the new value in the cycle after the write
        wr(tcc_pkg::ADDR_CMP2, 16'h4000);
        cnt <= 16'h4000;
        tick(4);
        rd(tcc_pkg::ADDR_FLAG, 16'h0000);
        hit(16'h4000);
        rd(tcc_pkg::ADDR_FLAG, 16'h0040);
        // multi-pin compare
        wr(tcc_pkg::ADDR_M1_MASK, 16'h00F8);
        wr(tcc_pkg::ADDR_M1_DATA, 16'h00A0);
        wr(tcc_pkg::ADDR_CMP1, 16'h5000);
        hit(16'h5000);
        `CHK(cpo, 5'h14)
        // shared channel as fourth capture, fed by software pin writes
        wr(tcc_pkg::ADDR_M1_MASK, 16'h0000);
        wr(tcc_pkg::ADDR_ACC, 16'h0004);
        wr(tcc_pkg::ADDR_SHARED, 16'h1234);
        rd(tcc_pkg::ADDR_SHARED, 16'hFFFF);
        wr(tcc_pkg::ADDR_EDGE, 16'h0040);
        step(16'h6000);
        wr(tcc_pkg::ADDR_PORT_DATA, 16'h0008);
        tick(6);
        rd(tcc_pkg::ADDR_SHARED, 16'h6000);
        wr(tcc_pkg::ADDR_ACC, 16'h0000);
        wr(tcc_pkg::ADDR_PORT_DATA, 16'h0000);
        step(16'h7000);
        wr(tcc_pkg::ADDR_PORT_DATA, 16'h0008);
        tick(6);
        rd(tcc_pkg::ADDR_SHARED, 16'h6000);
        end_sim();
    end
endmodule // timer_capture_compare_unit_test
